// file: sim/sdr_read_latency_table_tb_top.sv
// bench: three link pairs whose hosts run at different clock limits
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) \
  begin \
    compares++; \
    if ((g) !== (e)) begin \
      $display("CHECK FAILED %s exp %h got %h", nm, e, g); \
      num_errors++; \
    end \
  end
module sdr_read_latency_table_tb_top
  import srlt_exp_pkg::*;
;
  logic clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic req = 1'b0;
  logic scan = 1'b0;
  logic [7:0] offset = 8'h00;
  logic [2:0] done, sdone, found, pok, dseen, busy;
  logic [7:0] data [3];
  logic [7:0] base [3];
  logic [1:0] code [3];
  logic [7:0] dofs [3];
  logic [7:0] dbyte [3];
  int num_errors = 0;
  int compares = 0;

  always #2.5 clk_i = ~clk_i;

  // limits 80, 50 and 90 MHz: third row, second row, no row
  for (genvar g = 0; g < 3; g++) begin : pair
    srlt_link_if srlt_link_if_i ();
    srlt_host #(
      .HALF_CYC(2),
      .SCK_MHZ(g == 0 ? 8'h50 : g == 1 ? 8'h32 : 8'h5A)
    ) srlt_host_i (
      .clk_i(clk_i), .srst_i(srst_i), .link(srlt_link_if_i),
      .req_i(req), .offset_i(offset), .scan_i(scan), .busy_o(busy[g]),
      .done_o(done[g]), .data_o(data[g]), .scan_done_o(sdone[g]),
      .row_found_o(found[g]), .lat_code_o(code[g]),
      .row_base_o(base[g]), .plain_read_ok_o(pok[g])
    );
    srlt_dev srlt_dev_i (
      .link(srlt_link_if_i), .clk_i(clk_i), .srst_i(srst_i),
      .offset_o(dofs[g]), .byte_o(dbyte[g]), .offset_seen_o(dseen[g])
    );
    if (g == 0) begin : chk
      srlt_asserts srlt_asserts_i (
        .clk_i(clk_i), .srst_i(srst_i), .sck(srlt_link_if_i.sck),
        .cs_n(srlt_link_if_i.cs_n), .mosi(srlt_link_if_i.mosi),
        .miso_d(srlt_link_if_i.miso_d),
        .miso_oe(srlt_link_if_i.miso_oe), .miso(srlt_link_if_i.miso)
      );
    end
  end

  task print_verdict;
    if (num_errors == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic rd(input logic [7:0] ofs);
    logic seen;
    int i;
    seen = 1'b0;
    @(negedge clk_i);
    req = 1'b1;
    offset = ofs;
    for (i = 0; i < 300 && done[0] !== 1'b1; i++) begin
      @(negedge clk_i);
      if (dseen[0] === 1'b1)
        seen = 1'b1;
    end
    req = 1'b0;
    `CHK("busy", 3'b111, busy)
    for (int k = 0; k < 3; k++)
      `CHK("data", exp_byte(ofs), data[k])
    `CHK("dev offset", ofs, dofs[0])
    `CHK("dev byte", exp_byte(ofs), dbyte[0])
    `CHK("dev seen", 1'b1, seen)
  endtask

  task automatic rng(input logic [7:0] lo, input logic [7:0] hi);
    for (int a = lo; a <= hi; a++)
      rd(8'(a));
  endtask

  task automatic scan_all();
    logic [2:0] got;
    int i;
    got = 3'b000;
    @(negedge clk_i);
    scan = 1'b1;
    @(negedge clk_i);
    scan = 1'b0;
    for (i = 0; i < 600 && got !== 3'b111; i++) begin
      @(negedge clk_i);
      got = got | sdone;
    end
    `CHK("scan done", 3'b111, got)
    `CHK("scan idle", 3'b000, busy)
  endtask

  // generous bound: about fifty frames of some seventy cycles each
  initial begin
    repeat (20000) @(posedge clk_i);
    num_errors++;
    print_verdict();
  end

  initial begin
    repeat (6) @(posedge clk_i);
    @(negedge clk_i);
    srst_i = 1'b0;
    scan_all();
    `CHK("found 80", 1'b1, found[0])
    `CHK("code 80", 2'b00, code[0])
    `CHK("base 80", 8'h20, base[0])
    `CHK("plain 80", 1'b0, pok[0])
    `CHK("found 50", 1'b1, found[1])
    `CHK("code 50", 2'b11, code[1])
    `CHK("base 50", 8'h12, base[1])
    `CHK("plain 50", 1'b1, pok[1])
    `CHK("found 90", 1'b0, found[2])
    rng(8'h00, 8'h00);
    rng(8'h01, 8'h01);
    rng(8'h02, 8'h05);
    rng(8'h06, 8'h07);
    rng(8'h08, 8'h09);
    rng(8'h0A, 8'h0B);
    rng(8'h0C, 8'h0D);
    rng(8'h0E, 8'h0F);
    rng(8'h10, 8'h11);
    rng(8'h12, 8'h13);
    rng(8'h14, 8'h1B);
    rng(8'h1C, 8'h1D);
    rng(8'h1E, 8'h1F);
    rng(8'h20, 8'h21);
    rng(8'h22, 8'h23);
    rng(8'h24, 8'h29);
    rng(8'h2A, 8'h2D);
    rd(8'h58);
    rd(8'hFF);
    print_verdict();
  end
endmodule
`default_nettype wire

// file: sim/srlt_asserts.sv
// wire checks of the bytes served on the first link
`timescale 1ns/10ps
`default_nettype none
module srlt_asserts
  import srlt_exp_pkg::*;
(
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic sck,
  input wire logic cs_n,
  input wire logic mosi,
  input wire logic miso_d,
  input wire logic miso_oe,
  input wire logic miso
);
  logic sck_q;
  logic [4:0] nbit;
  logic [4:0] nfall;
  logic [7:0] ofs;
  logic [7:0] rx;
  // oversampled: sck is made from clk_i, so edges are seen without race
  always_ff @(posedge clk_i) begin
    sck_q <= sck;
    if (srst_i || cs_n) begin
      nbit <= 5'h00;
      nfall <= 5'h00;
    end else begin
      if (sck && !sck_q) begin
        nbit <= nbit + 5'h01;
        if (nbit < 5'h08)
          ofs <= {ofs[6:0], mosi};
      end
      // data bits are taken at sck falls eight to fifteen, early in the low phase, not late as the host does
      if (!sck && sck_q) begin
        nfall <= nfall + 5'h01;
        if (nfall >= 5'h07 && nfall <= 5'h0E)
          rx <= {rx[6:0], miso};
      end
    end
  end
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (srst_i);
  sequence s_end;
    $rose(cs_n) && nfall == 5'h10;
  endsequence
  property p_id;
    s_end |-> (ofs != 8'h00 || rx == 8'h90);
  endproperty
  a_id: assert property (p_id)
    else $error("identifier byte wrong");
  property p_len;
    s_end |-> (ofs != 8'h01 || rx == 8'h56);
  endproperty
  a_len: assert property (p_len)
    else $error("length byte wrong");
  property p_shape;
    s_end |-> (ofs < 8'h02 || ofs > 8'h05 || rx == exp_byte(ofs));
  endproperty
  a_shape: assert property (p_shape)
    else $error("row shape bytes wrong");
  property p_ops;
    s_end |-> (ofs < 8'h06 || ofs > 8'h11 || rx == exp_byte(ofs));
  endproperty
  a_ops: assert property (p_ops)
    else $error("header opcode wrong");
  property p_row2_hdr;
    s_end |-> (ofs < 8'h12 || ofs > 8'h13 || rx == exp_byte(ofs));
  endproperty
  a_row2_hdr: assert property (p_row2_hdr)
    else $error("second row limit or code wrong");
  property p_row2_simple;
    s_end |-> (ofs < 8'h14 || ofs > 8'h1B || rx == 8'h00);
  endproperty
  a_row2_simple: assert property (p_row2_simple)
    else $error("second row simple cycles wrong");
  property p_row2_io;
    s_end |-> (ofs < 8'h1C || ofs > 8'h1F || rx == exp_byte(ofs));
  endproperty
  a_row2_io: assert property (p_row2_io)
    else $error("second row io cycles wrong");
  property p_row3_hdr;
    s_end |-> (ofs < 8'h20 || ofs > 8'h21 || rx == exp_byte(ofs));
  endproperty
  a_row3_hdr: assert property (p_row3_hdr)
    else $error("third row limit or code wrong");
  property p_unsup;
    s_end |-> (ofs < 8'h22 || ofs > 8'h23 || rx == 8'hFF);
  endproperty
  a_unsup: assert property (p_unsup)
    else $error("plain read not marked unsupported");
  property p_row3_rest;
    s_end |-> (ofs < 8'h24 || ofs > 8'h2D || rx == exp_byte(ofs));
  endproperty
  a_row3_rest: assert property (p_row3_rest)
    else $error("third row cycles wrong");
  // all-ones marks must come from the table, not from the idle pull-up
  property p_drive;
    !cs_n |-> (miso_oe && miso == miso_d);
  endproperty
  a_drive: assert property (p_drive)
    else $error("table not driving its data line");
endmodule
`default_nettype wire

// file: sim/srlt_exp_pkg.sv
// expected bytes of the latency table, shared by bench and checker
`default_nettype none
package srlt_exp_pkg;
  localparam logic [7:0] TAB [46] = '{
    8'h90, 8'h56, 8'h06, 8'h0E, 8'h46, 8'h43, 8'h03, 8'h13,
    8'h0B, 8'h0C, 8'h3B, 8'h3C, 8'h6B, 8'h6C, 8'hBB, 8'hBC,
    8'hEB, 8'hEC, 8'h32, 8'h03, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h04, 8'h00, 8'h02, 8'h01,
    8'h50, 8'h00, 8'hFF, 8'hFF, 8'h00, 8'h08, 8'h00, 8'h08,
    8'h00, 8'h08, 8'h04, 8'h00, 8'h02, 8'h04
  };
  // rows past the third are not held and read all ones
  function automatic logic [7:0] exp_byte(input logic [7:0] ofs);
    return (ofs <= 8'h2D) ? TAB[ofs[5:0]] : 8'hFF;
  endfunction
endpackage
`default_nettype wire

// file: verilog/srlt_dev.sv
// table end: serves latency table bytes by offset on the link clock
`timescale 1ns/10ps
`default_nettype none
`include "srlt_params.svh"

// What this block does
// - offset zero returns the parameter identifier
// - offset one returns following byte count
// - six rows of fourteen, header F C
// - header lists plain read opcodes
// - header lists fast read opcodes
// - header lists dual-output read opcodes
// - header lists quad-output read opcodes
// - header lists dual in/out read opcodes
// - header ends with quad in/out opcodes
// - second row: 50 MHz, code 11b
// - second row simple reads: no cycles
// - second row dual io: four mode
// - second row quad io: two mode, one latency
// - third row: 80 MHz, code 00b
// - all-ones means unsupported; plain read there
// - third row simple reads: eight latency
// - third row dual/quad io cycle counts
module srlt_dev
  import srlt_pkg::*;
(
  srlt_link_if.dev link,
  input wire logic clk_i,
  input wire logic srst_i,
  output logic [7:0] offset_o,
  output logic [7:0] byte_o,
  output logic offset_seen_o
);

  // table contents; rows 4 to 6 are not held and read as fill
  function automatic srlt_byte_t rom_byte(input srlt_byte_t ofs);
    logic [3:0] col;
    srlt_byte_t val;
    col = 4'h0;
    val = `SRLT_FILL;
    if (ofs < `SRLT_OFS_HDR) begin
      case (ofs[1:0])
        2'h0: val = `SRLT_PARAM_ID;
        2'h1: val = `SRLT_PARAM_LEN;
        2'h2: val = `SRLT_ROW_COUNT;
        default: val = `SRLT_ROW_LEN;
      endcase
    end else if (ofs < `SRLT_OFS_ROW2) begin
      col = 4'(ofs - `SRLT_OFS_HDR);
      case (col)
        4'h0: val = `SRLT_ASCII_F;
        4'h1: val = `SRLT_ASCII_C;
        4'h2: val = `SRLT_OP_READ3;
        4'h3: val = `SRLT_OP_READ4;
        4'h4: val = `SRLT_OP_FAST3;
        4'h5: val = `SRLT_OP_FAST4;
        4'h6: val = `SRLT_OP_DOUT3;
        4'h7: val = `SRLT_OP_DOUT4;
        4'h8: val = `SRLT_OP_QOUT3;
        4'h9: val = `SRLT_OP_QOUT4;
        4'hA: val = `SRLT_OP_DIO3;
        4'hB: val = `SRLT_OP_DIO4;
        4'hC: val = `SRLT_OP_QIO3;
        default: val = `SRLT_OP_QIO4;
      endcase
    end else if (ofs < `SRLT_OFS_ROW3) begin
      col = 4'(ofs - `SRLT_OFS_ROW2);
      case (col)
        4'h0: val = `SRLT_ROW2_MHZ;
        4'h1: val = `SRLT_ROW2_CODE;
        4'hA: val = `SRLT_ROW2_DIO_MODE;
        4'hB: val = `SRLT_CYC_NONE;
        4'hC: val = `SRLT_ROW2_QIO_MODE;
        4'hD: val = `SRLT_ROW2_QIO_LAT;
        default: val = `SRLT_CYC_NONE;
      endcase
    end else if (ofs <= `SRLT_OFS_LAST) begin
      col = 4'(ofs - `SRLT_OFS_ROW3);
      case (col)
        4'h0: val = `SRLT_ROW3_MHZ;
        4'h1: val = `SRLT_ROW3_CODE;
        4'h2: val = `SRLT_CYC_UNSUP;
        4'h3: val = `SRLT_CYC_UNSUP;
        4'h4: val = `SRLT_CYC_NONE;
        4'h5: val = `SRLT_ROW3_LAT;
        4'h6: val = `SRLT_CYC_NONE;
        4'h7: val = `SRLT_ROW3_LAT;
        4'h8: val = `SRLT_CYC_NONE;
        4'h9: val = `SRLT_ROW3_LAT;
        4'hA: val = `SRLT_ROW3_DIO_MODE;
        4'hB: val = `SRLT_CYC_NONE;
        4'hC: val = `SRLT_ROW3_QIO_MODE;
        default: val = `SRLT_ROW3_QIO_LAT;
      endcase
    end
    return val;
  endfunction

  // ---- link clock domain ----
  logic [3:0] bit_cnt_reg;
  logic [3:0] bit_cnt_next;
  srlt_byte_t ofs_sh_reg;
  srlt_byte_t ofs_sh_next;
  srlt_byte_t out_sh_reg;
  srlt_byte_t out_sh_next;
  srlt_byte_t served_reg;
  srlt_byte_t served_next;
  logic ofs_valid_reg;
  logic ofs_valid_next;
  srlt_byte_t ofs_full;

  always_comb begin
    bit_cnt_next = bit_cnt_reg;
    ofs_sh_next = ofs_sh_reg;
    out_sh_next = out_sh_reg;
    served_next = served_reg;
    ofs_valid_next = ofs_valid_reg;
    ofs_full = {ofs_sh_reg[6:0], link.mosi};
    // saturate so that stray extra edges cannot wrap into a new offset
    if (bit_cnt_reg != 4'(`SRLT_FRAME_BITS - 1)) begin
      bit_cnt_next = bit_cnt_reg + 4'h1;
    end
    if (bit_cnt_reg < 4'(`SRLT_ADDR_BITS)) begin
      ofs_sh_next = ofs_full;
    end
    if (bit_cnt_reg == 4'(`SRLT_ADDR_BITS - 1)) begin
      out_sh_next = rom_byte(ofs_full);
      served_next = rom_byte(ofs_full);
      ofs_valid_next = 1'b1;
    end else if (bit_cnt_reg >= 4'(`SRLT_ADDR_BITS)) begin
      out_sh_next = {out_sh_reg[6:0], 1'b0};
    end
  end

  // link clock stops between frames, so the frame's own select clears state
  always_ff @(posedge link.sck or posedge link.cs_n) begin
    if (link.cs_n) begin
      bit_cnt_reg <= 4'h0;
      ofs_sh_reg <= 8'h00;
      out_sh_reg <= 8'h00;
      served_reg <= 8'h00;
      ofs_valid_reg <= 1'b0;
    end else begin
      bit_cnt_reg <= bit_cnt_next;
      ofs_sh_reg <= ofs_sh_next;
      out_sh_reg <= out_sh_next;
      served_reg <= served_next;
      ofs_valid_reg <= ofs_valid_next;
    end
  end

  assign link.miso_d = out_sh_reg[7];
  assign link.miso_oe = ~link.cs_n;

  // ---- system clock domain ----
  logic valid_s1_reg;
  logic valid_s2_reg;
  logic valid_s3_reg;
  srlt_byte_t offset_reg;
  srlt_byte_t offset_next;
  srlt_byte_t byte_reg;
  srlt_byte_t byte_next;
  logic seen_reg;
  logic seen_next;

  // offset and byte are loaded at the flag's rise and stay still past select end until the next frame's rise
  always_comb begin
    offset_next = offset_reg;
    byte_next = byte_reg;
    seen_next = 1'b0;
    if (valid_s2_reg && !valid_s3_reg) begin
      offset_next = ofs_sh_reg;
      byte_next = served_reg;
      seen_next = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      valid_s1_reg <= 1'b0;
      valid_s2_reg <= 1'b0;
      valid_s3_reg <= 1'b0;
      offset_reg <= 8'h00;
      byte_reg <= 8'h00;
      seen_reg <= 1'b0;
    end else begin
      valid_s1_reg <= ofs_valid_reg;
      valid_s2_reg <= valid_s1_reg;
      valid_s3_reg <= valid_s2_reg;
      offset_reg <= offset_next;
      byte_reg <= byte_next;
      seen_reg <= seen_next;
    end
  end

  assign offset_o = offset_reg;
  assign byte_o = byte_reg;
  assign offset_seen_o = seen_reg;

endmodule
`default_nettype wire

// file: verilog/srlt_host.sv
// reader end: fetches table bytes and picks the latency row
`timescale 1ns/10ps
`default_nettype none
`include "srlt_params.svh"

module srlt_host
  import srlt_pkg::*;
#(
  parameter int HALF_CYC = `SRLT_SCK_HALF_CYC,
  parameter logic [7:0] SCK_MHZ = 8'(`SRLT_SCK_MHZ)
) (
  input wire logic clk_i,
  input wire logic srst_i,
  srlt_link_if.host link,
  input wire logic req_i,
  input wire logic [7:0] offset_i,
  input wire logic scan_i,
  output logic busy_o,
  output logic done_o,
  output logic [7:0] data_o,
  output logic scan_done_o,
  output logic row_found_o,
  output logic [1:0] lat_code_o,
  output logic [7:0] row_base_o,
  output logic plain_read_ok_o
);

  srlt_host_st_t st_reg, st_next;
  srlt_scan_step_t step_reg, step_next;
  logic [4:0] cnt_reg, cnt_next;
  logic [3:0] bit_reg, bit_next;
  srlt_byte_t sh_out_reg, sh_out_next;
  srlt_byte_t sh_in_reg, sh_in_next;
  srlt_byte_t base_reg, base_next;
  logic sck_reg, sck_next;
  logic cs_n_reg, cs_n_next;
  logic mosi_reg, mosi_next;
  logic scan_reg, scan_next;
  logic found_reg, found_next;
  logic [1:0] code_reg, code_next;
  logic plain_ok_reg, plain_ok_next;
  logic scan_done_reg, scan_done_next;
  logic miso_s1_reg;
  logic miso_s2_reg;
  logic half_end;
  srlt_byte_t xfer_ofs;

  always_comb begin
    st_next = st_reg;
    step_next = step_reg;
    cnt_next = cnt_reg;
    bit_next = bit_reg;
    sh_out_next = sh_out_reg;
    sh_in_next = sh_in_reg;
    base_next = base_reg;
    sck_next = sck_reg;
    cs_n_next = cs_n_reg;
    mosi_next = mosi_reg;
    scan_next = scan_reg;
    found_next = found_reg;
    code_next = code_reg;
    plain_ok_next = plain_ok_reg;
    scan_done_next = 1'b0;
    half_end = (cnt_reg == 5'(HALF_CYC - 1));
    xfer_ofs = scan_reg ? base_reg + {6'h00, step_reg} : offset_i;
    unique case (st_reg)
      H_IDLE: begin
        if (!scan_reg && scan_i) begin
          scan_next = 1'b1;
          step_next = S_FREQ;
          base_next = `SRLT_OFS_ROW2;
          found_next = 1'b0;
          plain_ok_next = 1'b0;
        end else if (scan_reg || req_i) begin
          cs_n_next = 1'b0;
          sh_out_next = xfer_ofs;
          mosi_next = xfer_ofs[7];
          cnt_next = 5'h00;
          bit_next = 4'h0;
          st_next = H_LOW;
        end
      end
      H_LOW: begin
        cnt_next = cnt_reg + 5'h01;
        if (half_end) begin
          cnt_next = 5'h00;
          sck_next = 1'b1;
          st_next = H_HIGH;
          // sampled late in the low phase, long after the table moved it
          if (bit_reg >= 4'(`SRLT_ADDR_BITS)) begin
            sh_in_next = {sh_in_reg[6:0], miso_s2_reg};
          end
        end
      end
      H_HIGH: begin
        cnt_next = cnt_reg + 5'h01;
        if (half_end) begin
          cnt_next = 5'h00;
          sck_next = 1'b0;
          if (bit_reg == 4'(`SRLT_FRAME_BITS - 1)) begin
            st_next = H_TAIL;
          end else begin
            bit_next = bit_reg + 4'h1;
            sh_out_next = {sh_out_reg[6:0], 1'b0};
            mosi_next = sh_out_reg[6];
            st_next = H_LOW;
          end
        end
      end
      H_TAIL: begin
        cnt_next = cnt_reg + 5'h01;
        if (half_end) begin
          cnt_next = 5'h00;
          cs_n_next = 1'b1;
          st_next = H_DONE;
        end
      end
      H_DONE: begin
        st_next = H_IDLE;
        if (scan_reg) begin
          unique case (step_reg)
            S_FREQ: begin
              if (sh_in_reg >= SCK_MHZ) begin
                step_next = S_CODE;
              end else if (base_reg == `SRLT_OFS_ROW2) begin
                base_next = `SRLT_OFS_ROW3;
              end else begin
                scan_next = 1'b0;
                scan_done_next = 1'b1;
              end
            end
            S_CODE: begin
              code_next = sh_in_reg[1:0];
              step_next = S_PLAIN;
            end
            default: begin
              plain_ok_next = (sh_in_reg != `SRLT_CYC_UNSUP);
              found_next = 1'b1;
              scan_next = 1'b0;
              scan_done_next = 1'b1;
            end
          endcase
        end
      end
      default: st_next = H_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      st_reg <= H_IDLE;
      step_reg <= S_FREQ;
      cnt_reg <= 5'h00;
      bit_reg <= 4'h0;
      sh_out_reg <= 8'h00;
      sh_in_reg <= 8'h00;
      base_reg <= `SRLT_OFS_ROW2;
      sck_reg <= 1'b0;
      cs_n_reg <= 1'b1;
      mosi_reg <= 1'b0;
      scan_reg <= 1'b0;
      found_reg <= 1'b0;
      code_reg <= 2'h0;
      plain_ok_reg <= 1'b0;
      scan_done_reg <= 1'b0;
      miso_s1_reg <= 1'b1;
      miso_s2_reg <= 1'b1;
    end else begin
      st_reg <= st_next;
      step_reg <= step_next;
      cnt_reg <= cnt_next;
      bit_reg <= bit_next;
      sh_out_reg <= sh_out_next;
      sh_in_reg <= sh_in_next;
      base_reg <= base_next;
      sck_reg <= sck_next;
      cs_n_reg <= cs_n_next;
      mosi_reg <= mosi_next;
      scan_reg <= scan_next;
      found_reg <= found_next;
      code_reg <= code_next;
      plain_ok_reg <= plain_ok_next;
      scan_done_reg <= scan_done_next;
      miso_s1_reg <= link.miso;
      miso_s2_reg <= miso_s1_reg;
    end
  end

  assign link.sck = sck_reg;
  assign link.cs_n = cs_n_reg;
  assign link.mosi = mosi_reg;
  assign busy_o = (st_reg != H_IDLE) || scan_reg;
  assign done_o = (st_reg == H_DONE) && !scan_reg;
  assign data_o = sh_in_reg;
  assign scan_done_o = scan_done_reg;
  assign row_found_o = found_reg;
  assign lat_code_o = code_reg;
  assign row_base_o = base_reg;
  assign plain_read_ok_o = plain_ok_reg;

endmodule
`default_nettype wire

// file: verilog/srlt_link_if.sv
// serial link between the table reader and the table
`timescale 1ns/10ps
`default_nettype none
interface srlt_link_if;
  logic sck;
  logic cs_n;
  logic mosi;
  logic miso_d;
  logic miso_oe;
  logic miso;
  // idle line floats high through a pull-up
  assign miso = miso_oe ? miso_d : 1'b1;
  modport host (
    output sck,
    output cs_n,
    output mosi,
    input miso
  );
  modport dev (
    input sck,
    input cs_n,
    input mosi,
    output miso_d,
    output miso_oe
  );
endinterface
`default_nettype wire

// file: verilog/srlt_params.svh
// constants of the read latency table and of its serial link
`ifndef SRLT_PARAMS_SVH
`define SRLT_PARAMS_SVH

// parameter preamble
`define SRLT_PARAM_ID 8'h90
`define SRLT_PARAM_LEN 8'h56
`define SRLT_ROW_COUNT 8'h06
`define SRLT_ROW_LEN 8'h0E
`define SRLT_ASCII_F 8'h46
`define SRLT_ASCII_C 8'h43

// byte offsets inside the parameter
`define SRLT_OFS_ID 8'h00
`define SRLT_OFS_LEN 8'h01
`define SRLT_OFS_HDR 8'h04
`define SRLT_OFS_ROW2 8'h12
`define SRLT_OFS_ROW3 8'h20
`define SRLT_OFS_LAST 8'h2D

// column positions inside a row
`define SRLT_COL_FREQ 4'h0
`define SRLT_COL_CODE 4'h1
`define SRLT_COL_PLAIN 4'h2

// header row instruction codes
`define SRLT_OP_READ3 8'h03
`define SRLT_OP_READ4 8'h13
`define SRLT_OP_FAST3 8'h0B
`define SRLT_OP_FAST4 8'h0C
`define SRLT_OP_DOUT3 8'h3B
`define SRLT_OP_DOUT4 8'h3C
`define SRLT_OP_QOUT3 8'h6B
`define SRLT_OP_QOUT4 8'h6C
`define SRLT_OP_DIO3 8'hBB
`define SRLT_OP_DIO4 8'hBC
`define SRLT_OP_QIO3 8'hEB
`define SRLT_OP_QIO4 8'hEC

// row contents
`define SRLT_ROW2_MHZ 8'h32
`define SRLT_ROW2_CODE 8'h03
`define SRLT_ROW3_MHZ 8'h50
`define SRLT_ROW3_CODE 8'h00
`define SRLT_CYC_NONE 8'h00
`define SRLT_CYC_UNSUP 8'hFF
`define SRLT_ROW2_DIO_MODE 8'h04
`define SRLT_ROW2_QIO_MODE 8'h02
`define SRLT_ROW2_QIO_LAT 8'h01
`define SRLT_ROW3_LAT 8'h08
`define SRLT_ROW3_DIO_MODE 8'h04
`define SRLT_ROW3_QIO_MODE 8'h02
`define SRLT_ROW3_QIO_LAT 8'h04
`define SRLT_FILL 8'hFF

// link timing and framing
`define SRLT_CLK_PERIOD_NS 5
`define SRLT_SCK_PERIOD_NS 130
`define SRLT_SCK_HALF_CYC ((`SRLT_SCK_PERIOD_NS / 2 + `SRLT_CLK_PERIOD_NS - 1) / `SRLT_CLK_PERIOD_NS)
`define SRLT_SCK_MHZ (1000 / `SRLT_SCK_PERIOD_NS)
`define SRLT_ADDR_BITS 8
`define SRLT_FRAME_BITS 16

`endif

// file: verilog/srlt_pkg.sv
// types shared by both ends of the latency table link
`default_nettype none
package srlt_pkg;
  typedef logic [7:0] srlt_byte_t;
  typedef enum logic [2:0] {
    H_IDLE = 3'b000,
    H_LOW = 3'b001,
    H_HIGH = 3'b010,
    H_TAIL = 3'b011,
    H_DONE = 3'b100
  } srlt_host_st_t;
  typedef enum logic [1:0] {
    S_FREQ = 2'b00,
    S_CODE = 2'b01,
    S_PLAIN = 2'b10
  } srlt_scan_step_t;
endpackage
`default_nettype wire
